// >>> design/sss_top.sv
/*
 * sync slicer with glitch filter, composite sync separator, sync
 * activity detection and pll sync source selection, with an
 * AXI4-Lite register slave and one level interrupt.
 * assumes luma samples arrive on aclk from the adc; sync pins are async.
 */
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

// Function
// (R01) two hsync, three luma inputs, auto pick
// (R02) 5-bit threshold, default 11, scale code/31
// (R03) slicer result drives sliced sync pin
// (R04) glitch filter three cutoffs, bypass at reset
// (R05) separate hsync and vsync from sliced luma
// (R06) detect vsync and hsync activity separately
// (R07) host: vsync active means 5-wire source
// (R08) host: 5-wire uses hsync as plain hsync
// (R09) auto: both pins active use pins
// (R10) host: hsync only means 4-wire composite
// (R11) auto: no vsync decodes from hsync pin
// (R12) host: csync on both pins, force separated
// (R13) xor composite type, default after reset
// (R14) inclusive-or composite type also accepted
// (R15) auto: no pin activity selects luma
// (R16) activity results in status register 14h
// (R17) activity times out with no edge
module sss_top #(
	parameter int ACT_WIN = sss_pkg::ACT_WIN_CYC,
	parameter int VSEP = sss_pkg::VSEP_CYC,
	parameter logic [7:0] SLICE_FS = 8'h40,
	parameter logic [7:0] HYST = 8'h02
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [1:0] hsync_pin,
	input wire logic vsync_pin,
	input wire logic [2:0][7:0] luma_sample,
	output logic sliced_sync_out,
	output logic pll_hsync_out,
	output logic pll_vsync_out,
	output logic irq
);
	import sss_pkg::*;

	localparam int AW = $clog2(ACT_WIN + 1);
	localparam int VW = $clog2(VSEP + 1);

	function automatic logic [7:0] slice_level(input logic [4:0] code);
		logic [15:0] p;
		p = 16'(code) * 16'(SLICE_FS);
		return 8'(p / 16'(THR_MAX));
	endfunction

	// ********************************
	// state
	// ********************************
	sss_sel_s sel_q, sel_d;
	logic [4:0] thr_q, thr_d;
	sss_filt_e filt_mode_q, filt_mode_d;
	logic [3:0] ist_q, ist_d, imask_q, imask_d;
	logic [2:0] sy1_q, sy2_q, prv_q;
	logic [2:0] sy1_d, sy2_d, prv_d;
	logic [7:0] filt_q, filt_d;
	logic sl_q, sl_d, sl_prv_q, sl_prv_d;
	logic [3:0][AW-1:0] act_q, act_d;
	logic [3:0] act_prv_q, act_prv_d;
	logic [1:0][VW-1:0] wcnt_q, wcnt_d;
	logic [1:0] sep_prv_q, sep_prv_d, sep_vs_q, sep_vs_d, sep_hs_q, sep_hs_d;
	logic hs_out_q, hs_out_d, vs_out_q, vs_out_d, irq_q, irq_d;
	sss_stat_s stat_q, stat_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdat_q, wdat_d;
	logic wstb_q, wstb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic awready_q, wready_q, arready_q;

	// combinational helpers
	logic [3:0] act_now, act_edge;
	logic [1:0] sep_in;
	logic [7:0] src, lvl;
	logic [8:0] diff;
	logic hs_pin_sel;
	sss_hsrc_e hsrc;
	logic vs_from_pin, do_wr;
	logic [31:0] rmux;
	logic rerr;

	// ********************************
	// sync pins, slicer and glitch filter
	// ********************************
	always_comb begin
		// first stage is read only by the second
		sy1_d = {vsync_pin, hsync_pin};
		sy2_d = sy1_q;
		prv_d = sy2_q;
		src = luma_sample[sel_q.luma_sel == 2'b11 ? 2'd0 : sel_q.luma_sel]; // [R01]
		diff = {1'b0, src} - {1'b0, filt_q};
		unique case (filt_mode_q) // [R04]
			FILT_BYPASS: filt_d = src;
			FILT_2M5: filt_d = filt_q + {{3{diff[8]}}, diff[7:3]};
			FILT_10M: filt_d = filt_q + {{2{diff[8]}}, diff[7:2]};
			FILT_33M: filt_d = filt_q + {diff[8], diff[7:1]};
		endcase
		lvl = slice_level(thr_q); // [R02]
		// hysteresis: release only once the sample clears level plus margin
		if (sl_q) begin
			sl_d = filt_q < (lvl + HYST);
		end else begin
			sl_d = filt_q < lvl;
		end
		sl_prv_d = sl_q;
	end

	// ********************************
	// activity detectors: hs0, hs1, vs, sliced luma
	// ********************************
	always_comb begin
		act_edge = {sl_q ^ sl_prv_q, sy2_q ^ prv_q};
		for (int i = 0; i < 4; i++) begin
			if (act_edge[i]) begin
				act_d[i] = AW'(ACT_WIN); // [R17]
			end else if (act_q[i] != '0) begin
				act_d[i] = act_q[i] - AW'(1); // [R17]
			end else begin
				act_d[i] = act_q[i];
			end
			act_now[i] = act_q[i] != '0; // [R06]
		end
		act_prv_d = act_now;
	end

	// ********************************
	// sync separators: 0 from sliced luma, 1 from hsync pin
	// ********************************
	always_comb begin
		hs_pin_sel = sel_q.auto_hs ? ~act_now[0] : (sel_q.hs_man == HS_PIN1);
		sep_in = {hs_pin_sel ? sy2_q[1] : sy2_q[0], sl_q}; // [R05] [R11]
		for (int c = 0; c < 2; c++) begin
			sep_prv_d[c] = sep_in[c];
			wcnt_d[c] = wcnt_q[c];
			sep_vs_d[c] = sep_vs_q[c];
			if (sep_in[c]) begin
				if (wcnt_q[c] != VW'(VSEP)) begin
					wcnt_d[c] = wcnt_q[c] + VW'(1);
				end
				// a pulse wider than a line sync is a broad vertical pulse
				if (wcnt_q[c] == VW'(VSEP - 1)) begin
					sep_vs_d[c] = 1'b1; // [R05]
				end
			end else begin
				wcnt_d[c] = '0;
				if (sep_prv_q[c] && wcnt_q[c] != VW'(VSEP)) begin
					sep_vs_d[c] = 1'b0;
				end
			end
			if (sel_q.csync_or) begin
				sep_hs_d[c] = sep_in[c] & ~sep_vs_q[c]; // [R14]
			end else begin
				sep_hs_d[c] = sep_in[c] ^ sep_vs_q[c]; // [R13]
			end
		end
	end

	// ********************************
	// pll source selection
	// ********************************
	always_comb begin
		if (sel_q.auto_hs) begin
			if (act_now[0]) begin
				hsrc = HS_PIN0; // [R01]
			end else if (act_now[1]) begin
				hsrc = HS_PIN1;
			end else begin
				hsrc = HS_LUMA; // [R15]
			end
		end else if (sel_q.hs_man == 2'b11) begin
			hsrc = HS_LUMA;
		end else begin
			hsrc = sss_hsrc_e'(sel_q.hs_man);
		end
		if (sel_q.auto_vs) begin
			vs_from_pin = act_now[2] && hsrc != HS_LUMA; // [R09] [R11]
		end else begin
			vs_from_pin = ~sel_q.vs_sep;
		end
		unique case (hsrc)
			HS_PIN0: hs_out_d = sy2_q[0]; // [R09]
			HS_PIN1: hs_out_d = sy2_q[1];
			default: hs_out_d = sep_hs_q[0];
		endcase
		if (vs_from_pin) begin
			vs_out_d = sy2_q[2]; // [R09]
		end else if (hsrc == HS_LUMA) begin
			vs_out_d = sep_vs_q[0]; // [R05] [R15]
		end else begin
			vs_out_d = sep_vs_q[1]; // [R11]
		end
		stat_d = '{vs_pin: vs_from_pin, hs_src: hsrc, luma_act: act_now[3],
			vs_act: act_now[2], hs1_act: act_now[1], hs0_act: act_now[0]}; // [R16]
	end

	// ********************************
	// AXI4-Lite slave
	// ********************************
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		waddr_d = waddr_q;
		wdat_d = wdat_q;
		wstb_d = wstb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		sel_d = sel_q;
		thr_d = thr_q;
		filt_mode_d = filt_mode_q;
		imask_d = imask_q;
		ist_d = ist_q;
		if (awvalid && awready_q) begin
			aw_have_d = 1'b1;
			waddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdat_d = wdata;
			wstb_d = wstrb[0];
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		do_wr = aw_have_q && w_have_q && !bvalid_q;
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (waddr_q)
				ADDR_SEL: if (wstb_q) sel_d = wdat_q[7:0];
				ADDR_THR: if (wstb_q) thr_d = wdat_q[4:0]; // [R02]
				ADDR_FILT: if (wstb_q) filt_mode_d = sss_filt_e'(wdat_q[1:0]); // [R04]
				ADDR_MASK: if (wstb_q) imask_d = wdat_q[3:0];
				ADDR_IRQ: if (wstb_q) ist_d = ist_q & ~wdat_q[3:0];
				ADDR_STAT: bresp_d = RESP_OKAY;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		// a change of any activity flag is an event; set beats clear
		ist_d = ist_d | (act_now ^ act_prv_q);
		rerr = 1'b0;
		unique case (araddr)
			ADDR_SEL: rmux = {24'h0, sel_q};
			ADDR_THR: rmux = {27'h0, thr_q};
			ADDR_FILT: rmux = {30'h0, filt_mode_q};
			ADDR_STAT: rmux = {25'h0, stat_q}; // [R16]
			ADDR_IRQ: rmux = {28'h0, ist_q};
			ADDR_MASK: rmux = {28'h0, imask_q};
			default: begin
				rmux = 32'h0;
				rerr = 1'b1;
			end
		endcase
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d = rmux;
			rresp_d = rerr ? RESP_SLVERR : RESP_OKAY;
		end
		irq_d = |(ist_d & imask_d);
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= SEL_RST; // [R13]
			thr_q <= THR_RST; // [R02]
			filt_mode_q <= FILT_BYPASS; // [R04]
			imask_q <= 4'h0;
			ist_q <= 4'h0;
			sy1_q <= 3'h0;
			sy2_q <= 3'h0;
			prv_q <= 3'h0;
			filt_q <= 8'hff;
			sl_q <= 1'b0;
			sl_prv_q <= 1'b0;
			act_q <= '0;
			act_prv_q <= 4'h0;
			wcnt_q <= '0;
			sep_prv_q <= 2'h0;
			sep_vs_q <= 2'h0;
			sep_hs_q <= 2'h0;
			hs_out_q <= 1'b0;
			vs_out_q <= 1'b0;
			irq_q <= 1'b0;
			stat_q <= '0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= 8'h0;
			wdat_q <= 32'h0;
			wstb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0;
		end else begin
			sel_q <= sel_d;
			thr_q <= thr_d;
			filt_mode_q <= filt_mode_d;
			imask_q <= imask_d;
			ist_q <= ist_d;
			sy1_q <= sy1_d;
			sy2_q <= sy2_d;
			prv_q <= prv_d;
			filt_q <= filt_d;
			sl_q <= sl_d;
			sl_prv_q <= sl_prv_d;
			act_q <= act_d;
			act_prv_q <= act_prv_d;
			wcnt_q <= wcnt_d;
			sep_prv_q <= sep_prv_d;
			sep_vs_q <= sep_vs_d;
			sep_hs_q <= sep_hs_d;
			hs_out_q <= hs_out_d;
			vs_out_q <= vs_out_d;
			irq_q <= irq_d;
			stat_q <= stat_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			waddr_q <= waddr_d;
			wdat_q <= wdat_d;
			wstb_q <= wstb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// ready flags are registered so every output leaves a flip-flop;
	// they stay low while a response waits so nothing is taken twice
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			awready_q <= !aw_have_d && !bvalid_d;
			wready_q <= !w_have_d && !bvalid_d;
			arready_q <= !rvalid_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign arready = arready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign sliced_sync_out = sl_q; // [R03]
	assign pll_hsync_out = hs_out_q;
	assign pll_vsync_out = vs_out_q;
	assign irq = irq_q;

endmodule

// >>> inc/sss_pkg.sv
/*
 * constants, register map and carrier types of the sync slicer,
 * separator and source selector.
 * assumes a single 40 MHz clock and an AXI4-Lite register port.
 */
package sss_pkg;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_KHZ = 40000;
	localparam int ACT_WIN_MS = 50;
	localparam int ACT_WIN_CYC = ACT_WIN_MS * CLK_KHZ;
	localparam int VSEP_US = 10;
	localparam int VSEP_CYC = VSEP_US * CLK_KHZ / 1000;

	// ********************************
	// register map: index, byte address is four times it
	// ********************************
	localparam logic [7:0] IDX_SEL = 8'h0e;
	localparam logic [7:0] IDX_THR = 8'h10;
	localparam logic [7:0] IDX_FILT = 8'h11;
	localparam logic [7:0] IDX_STAT = 8'h14;
	localparam logic [7:0] IDX_IRQ = 8'h18;
	localparam logic [7:0] IDX_MASK = 8'h19;
	localparam logic [7:0] ADDR_SEL = 8'(IDX_SEL * 4);
	localparam logic [7:0] ADDR_THR = 8'(IDX_THR * 4);
	localparam logic [7:0] ADDR_FILT = 8'(IDX_FILT * 4);
	localparam logic [7:0] ADDR_STAT = 8'(IDX_STAT * 4);
	localparam logic [7:0] ADDR_IRQ = 8'(IDX_IRQ * 4);
	localparam logic [7:0] ADDR_MASK = 8'(IDX_MASK * 4);

	localparam logic [4:0] THR_RST = 5'h0b;
	localparam logic [4:0] THR_MAX = 5'h1f;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FILT_BYPASS = 2'b00,
		FILT_2M5 = 2'b01,
		FILT_10M = 2'b10,
		FILT_33M = 2'b11
	} sss_filt_e;

	typedef enum logic [1:0] {
		HS_PIN0 = 2'b00,
		HS_PIN1 = 2'b01,
		HS_LUMA = 2'b10
	} sss_hsrc_e;

	// selection register, bits 7..0
	typedef struct packed {
		logic [1:0] hs_man;
		logic [1:0] luma_sel;
		logic csync_or;
		logic vs_sep;
		logic auto_vs;
		logic auto_hs;
	} sss_sel_s;
	localparam sss_sel_s SEL_RST = 8'h03;

	// status register, bits 6..0
	typedef struct packed {
		logic vs_pin;
		logic [1:0] hs_src;
		logic luma_act;
		logic vs_act;
		logic hs1_act;
		logic hs0_act;
	} sss_stat_s;

endpackage

// >>> sim/sss_properties.sv
/*
 * concurrent checks on the register port and reset of the sync block.
 * assumes it is bound into sss_top; one clock domain.
 */
`timescale 1ns/1ps
module sss_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic pll_hsync_out,
	input wire logic irq
);
	// ****************
	// handshake and reset checks
	// ****************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write taken without response");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read taken without data");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	b_done_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	r_done_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read data repeated");
	aw_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while one is open");
	ar_block_a: assert property (rvalid |-> !arready)
		else $error("read accepted while one is open");
	rst_quiet_a: assert property (disable iff (1'b0)
		!aresetn |=> !bvalid && !rvalid && !irq && !pll_hsync_out)
		else $error("outputs not quiet in reset");
	cover property (bvalid && bready);
	cover property (rvalid && rready);
	cover property ($rose(irq));
endmodule

// >>> sim/sss_source.sv
/*
 * video source model: sync pins and luma streams for 3, 4, 5 wire.
 * assumes the bench picks the wiring; undriven pins pulled low.
 */
`timescale 1ns/1ps
module sss_source (
	input wire logic aclk,
	input wire logic [1:0] mode,
	output logic [1:0] hsync_pin,
	output logic vsync_pin,
	output logic [2:0][7:0] luma_sample
);
	// ****************
	// 32-cycle lines, 8 lines a frame
	// ****************
	logic [7:0] cnt_q = 8'h00;
	logic [7:0] cnt_d;
	logic hs, vs, cs;
	always_comb cnt_d = cnt_q + 8'h01;
	always_ff @(posedge aclk) cnt_q <= cnt_d;
	// vsync starts eight cycles into a line so its edge never meets an hsync edge
	assign hs = cnt_q[4:0] < 5'h03;
	assign vs = cnt_q >= 8'h28 && cnt_q < 8'h48;
	assign cs = hs ^ vs;
	// mode 0 luma only, 1 composite on pin 0, 2 separate pins, 3 silent
	always_comb begin
		hsync_pin[1] = 1'b0;
		hsync_pin[0] = (mode == 2'h2) ? hs : (mode == 2'h1 && cs);
		vsync_pin = mode == 2'h2 && vs;
		luma_sample = {8'h80, 8'h80, (mode == 2'h0 && cs) ? 8'h00 : 8'h80};
	end
endmodule

// >>> sim/sss_top_tb.sv
/*
 * self-checking bench of the sync block: register rows, reset values,
 * then 5, 4 and 3 wire sources with activity, selection and interrupt.
 * assumes sss_source drives the sync side.
 */
`timescale 1ns/1ps
module sss_top_tb;
	import sss_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic [1:0] e;
	} sss_row_s;
	// ****************
	// signals and rows
	// ****************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rdv;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, hsync_pin, rs;
	logic [1:0] mode = 2'h3;
	logic vsync_pin, sliced_sync_out, pll_hsync_out, pll_vsync_out, irq;
	logic [2:0][7:0] luma_sample;
	int checks = 0, miscompares = 0;
	// edges before bready or rready rise; 0 raises them with the request
	int lag = 0;
	sss_row_s rows [11] = '{
		'{ADDR_THR, 32'h1f, 32'h1f, RESP_OKAY},
		'{ADDR_THR, 32'h20, 32'h00, RESP_OKAY},
		'{ADDR_FILT, 32'h01, 32'h01, RESP_OKAY},
		'{ADDR_FILT, 32'h02, 32'h02, RESP_OKAY},
		'{ADDR_FILT, 32'h03, 32'h03, RESP_OKAY},
		'{ADDR_FILT, 32'h00, 32'h00, RESP_OKAY},
		'{ADDR_SEL, 32'h0b, 32'h0b, RESP_OKAY},
		'{ADDR_SEL, 32'h03, 32'h03, RESP_OKAY},
		'{ADDR_MASK, 32'h0f, 32'h0f, RESP_OKAY},
		'{ADDR_MASK, 32'h00, 32'h00, RESP_OKAY},
		'{8'h7c, 32'h05, 32'h00, RESP_SLVERR}
	};
	always #12.5 aclk = ~aclk;
	sss_top #(.ACT_WIN(400), .VSEP(20)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .hsync_pin, .vsync_pin, .luma_sample,
		.sliced_sync_out, .pll_hsync_out, .pll_vsync_out, .irq);
	sss_source src (.aclk, .mode, .hsync_pin, .vsync_pin, .luma_sample);
	// ****************
	// tasks
	// ****************
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic guard(input int n);
		if (n >= 600) begin
			miscompares++;
			$display("FAIL at %0t: wait ran out", $time);
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= lag == 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (n == lag) bready <= 1'b1;
		end while (!(bvalid === 1'b1 && bready) && n < 600);
		r = bresp;
		bready <= 1'b0;
		guard(n);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= lag == 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (n == lag) rready <= 1'b1;
		end while (!(rvalid === 1'b1 && rready) && n < 600);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		guard(n);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, rdv, rs);
		chk(rdv, e);
		chk(32'(rs), 32'(RESP_OKAY));
	endtask
	// k selects the sliced sync, else the pll vsync
	task automatic wait_hi(input bit k);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while ((k ? sliced_sync_out : pll_vsync_out) !== 1'b1 && n < 600);
		guard(n);
	endtask
	// a pin 0 hsync pulse reaches the pll output three edges later
	task automatic hs_follow();
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (hsync_pin[0] !== 1'b0 && n < 600);
		do begin
			@(posedge aclk);
			n++;
		end while (hsync_pin[0] !== 1'b1 && n < 600);
		guard(n);
		repeat (3) @(posedge aclk);
		chk({31'h0, pll_hsync_out}, 32'h1);
		repeat (3) @(posedge aclk);
		chk({31'h0, pll_hsync_out}, 32'h0);
	endtask
	task automatic irq_is(input logic e);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rs);
			chk(32'(rs), 32'(rows[i].e));
			rd(rows[i].a, rdv, rs);
			chk(rdv, rows[i].r);
			chk(32'(rs), 32'(rows[i].e));
		end
		$display("register rows done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(ADDR_THR, 32'(THR_RST));
		rchk(ADDR_SEL, 32'(SEL_RST));
		rchk(ADDR_FILT, 32'h0);
		rchk(ADDR_MASK, 32'h0);
		rchk(ADDR_IRQ, 32'h0);
		lag = 4;
		wr(ADDR_MASK, 32'h0, rs);
		chk(32'(rs), 32'(RESP_OKAY));
		rchk(ADDR_THR, 32'(THR_RST));
		lag = 0;
		$display("reset values done");
		mode <= 2'h2;
		repeat (1000) @(posedge aclk);
		rchk(ADDR_STAT, 32'h45);
		rchk(ADDR_IRQ, 32'h05);
		irq_is(1'b0);
		wait_hi(1'b0);
		hs_follow();
		wr(ADDR_MASK, 32'h0f, rs);
		irq_is(1'b1);
		wr(ADDR_IRQ, 32'h0f, rs);
		irq_is(1'b0);
		$display("five wire done");
		mode <= 2'h1;
		repeat (1000) @(posedge aclk);
		rchk(ADDR_STAT, 32'h01);
		rchk(ADDR_IRQ, 32'h04);
		irq_is(1'b1);
		wait_hi(1'b0);
		wr(ADDR_SEL, 32'h01, rs);
		rchk(ADDR_STAT, 32'h41);
		wr(ADDR_SEL, 32'h05, rs);
		rchk(ADDR_STAT, 32'h01);
		wait_hi(1'b0);
		wr(ADDR_SEL, 32'h03, rs);
		wr(ADDR_MASK, 32'h0b, rs);
		irq_is(1'b0);
		$display("four wire done");
		mode <= 2'h0;
		repeat (1000) @(posedge aclk);
		wr(ADDR_STAT, 32'h7f, rs);
		chk(32'(rs), 32'(RESP_OKAY));
		rchk(ADDR_STAT, 32'h28);
		wait_hi(1'b1);
		wait_hi(1'b0);
		rchk(ADDR_IRQ, 32'h0d);
		irq_is(1'b1);
		$display("three wire done");
		wrap_up();
	end
endmodule
bind sss_top sss_properties chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .pll_hsync_out,
	.irq);
